// ==== common/rsp_cfg.svh ====
/*
 * Constants of the reader serial host port: register offsets, field
 * positions, command codes, reset values and FIFO levels.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH

// ****************************************************************
// Word format and address word fields
// ****************************************************************
`define RSP_WORD_BITS 8
`define RSP_CW_CMD 7
`define RSP_CW_READ 6
`define RSP_CW_CONT 5

// ****************************************************************
// Register offsets and command codes
// ****************************************************************
`define RSP_NUM_GEN 12
`define RSP_ADDR_IRQ 5'h0C
`define RSP_ADDR_MASK 5'h0D
`define RSP_ADDR_RSSI 5'h0F
`define RSP_ADDR_FIFO_STAT 5'h1C
`define RSP_ADDR_FIFO 5'h1F
`define RSP_CMD_FIFO_RESET 5'h0F
`define RSP_READ_IRQ_CONT 8'h6C

// ****************************************************************
// Interrupt status bits and reset values
// ****************************************************************
`define RSP_IRQ_TX 7
`define RSP_IRQ_RX 6
`define RSP_IRQ_FIFO 5
`define RSP_IRQ_ERR 4
`define RSP_STAT_TX_DONE 8'h80
`define RSP_IRQ_RESET 8'h00
`define RSP_MASK_RESET 8'h00

// ****************************************************************
// Strap decode and FIFO levels
// ****************************************************************
`define RSP_STRAP_SS 3'h1
`define RSP_FIFO_DEPTH 12
`define RSP_FIFO_LAST 4'hB
`define RSP_FIFO_HIGH 4'h9
`define RSP_FIFO_LOW 4'h3
`define RSP_FST_HIGH 6
`define RSP_FST_LOW 5
`define RSP_FST_OVF 4

`endif

// ==== common/rsp_pkg.sv ====
/*
 * Types of the reader serial host port: transfer states and the packed
 * state record of the port.
 * Assumes rsp_cfg.svh is on the include path.
 */
`include "rsp_cfg.svh"

package rsp_pkg;

   // ****************************************************************
   // Transfer states
   // ****************************************************************
   typedef enum logic [1:0] {
      RSP_IDLE = 2'b00,
      RSP_CMD = 2'b01,
      RSP_WDATA = 2'b10,
      RSP_RDATA = 2'b11
   } rsp_state_t;

   // ****************************************************************
   // State of the port except the FIFO memory in rsp_fifo_mem
   // ****************************************************************
   typedef struct packed {
      logic [2:0] sclk_sync;
      logic [2:0] mosi_sync;
      logic [2:0] ss_sync;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic [1:0] settle;
      logic strap_done;
      logic mode_ok;
      logic ss_mode;
      rsp_state_t state;
      logic [2:0] bitcnt;
      logic [7:0] rx_sr;
      logic [7:0] tx_sr;
      logic miso;
      logic [4:0] addr;
      logic cont;
      logic need_load;
      logic irq_rd;
      logic [7:0] irq;
      logic [`RSP_NUM_GEN-1:0][7:0] gen;
      logic [7:0] mask;
      logic [7:0] rssi;
      logic [3:0] wr_ptr;
      logic [3:0] rd_ptr;
      logic [3:0] count;
      logic ovf;
   } rsp_regs_t;

endpackage

// ==== hw/rsp_fifo_mem.sv ====
/*
 * Small byte memory behind the receive FIFO: one write port, one read
 * address, read data from a register one clock after the address.
 * Assumes the caller keeps the pointers inside the depth.
 */
`timescale 1ns/1ns
`include "rsp_cfg.svh"

module rsp_fifo_mem
   import rsp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = `RSP_FIFO_DEPTH
) (
   // Clock
   input wire logic i_clock,
   // Write port
   input wire logic i_wr_en,
   input wire logic [3:0] i_wr_addr,
   input wire logic [WIDTH-1:0] i_wr_data,
   // Read port
   input wire logic [3:0] i_rd_addr,
   output logic [WIDTH-1:0] o_rd_data
);

   logic [WIDTH-1:0] mem_reg [DEPTH];

   // Storage and registered read
   always_ff @(posedge i_clock) begin
      if (i_wr_en) begin
         mem_reg[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem_reg[i_rd_addr];
   end

endmodule

// ==== hw/rsp_serial_port.sv ====
/*
 * Serial host port of a reader front end: strap selected serial mode
 * with or without slave select, register access, interrupt status with
 * dummy read clear, receive FIFO, RSSI capture.
 * Assumes the air side gives one-cycle event pulses on i_clock and that
 * the host serial clock is much slower than i_clock.
 */
`timescale 1ns/1ns
`include "rsp_cfg.svh"

module rsp_serial_port
   import rsp_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // Interface select straps
   input wire logic [2:0] i_strap,
   // Serial pins
   input wire logic i_sclk,
   input wire logic i_mosi,
   input wire logic i_ss_n,
   output logic o_miso,
   output logic o_miso_oe_n,
   // Air side events
   input wire logic i_tx_done,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_end,
   input wire logic i_rx_error,
   input wire logic [7:0] i_rssi,
   // Interrupt to host
   output logic o_irq
);

   rsp_regs_t r_reg;
   rsp_regs_t r_next;
   logic [7:0] fifo_rdata;
   logic fifo_push;
   logic fifo_pop;
   logic fifo_clr;

   // ****************************************************************
   // Receive FIFO storage
   // ****************************************************************
   rsp_fifo_mem #(
      .WIDTH(8),
      .DEPTH(`RSP_FIFO_DEPTH)
   ) u_mem (
      .i_clock(i_clock),
      .i_wr_en(fifo_push),
      .i_wr_addr(r_reg.wr_ptr),
      .i_wr_data(i_rx_data),
      .i_rd_addr(r_reg.rd_ptr),
      .o_rd_data(fifo_rdata)
   );

   // Pointer step with wrap at the FIFO depth
   function automatic logic [3:0] ptr_inc(input logic [3:0] p);
      ptr_inc = (p == `RSP_FIFO_LAST) ? 4'h0 : p + 4'h1;
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic sclk_rise;
      logic sclk_fall;
      logic sclk_hi;
      logic mosi_rise;
      logic mosi_fall;
      logic ss_hi;
      logic start_c;
      logic stop_c;
      logic [7:0] word;
      logic [7:0] rd_val;
      logic [7:0] fstat;
      logic [7:0] irq_set;
      logic [3:0] cnt_next;
      r_next = r_reg;
      fifo_push = 1'b0;
      fifo_pop = 1'b0;
      fifo_clr = 1'b0;
      irq_set = 8'h00;
      // Pin synchronisers, stage 0 read by stage 1 only
      r_next.sclk_sync = {r_reg.sclk_sync[1:0], i_sclk};
      r_next.mosi_sync = {r_reg.mosi_sync[1:0], i_mosi};
      r_next.ss_sync = {r_reg.ss_sync[1:0], i_ss_n};
      r_next.strap_s1 = i_strap;
      r_next.strap_s2 = r_reg.strap_s1;
      sclk_hi = r_reg.sclk_sync[1];
      sclk_rise = r_reg.sclk_sync[1] & ~r_reg.sclk_sync[2];
      sclk_fall = ~r_reg.sclk_sync[1] & r_reg.sclk_sync[2];
      mosi_rise = r_reg.mosi_sync[1] & ~r_reg.mosi_sync[2];
      mosi_fall = ~r_reg.mosi_sync[1] & r_reg.mosi_sync[2];
      ss_hi = r_reg.ss_sync[1];
      // Straps caught once after synchroniser settles
      if (r_reg.settle != 2'h3) begin
         r_next.settle = r_reg.settle + 2'h1;
      end else if (!r_reg.strap_done) begin
         r_next.strap_done = 1'b1;
         r_next.mode_ok = (r_reg.strap_s2 != 3'h0) && (r_reg.strap_s2 != 3'h7);
         r_next.ss_mode = (r_reg.strap_s2 == `RSP_STRAP_SS);
      end
      // Register read view
      fstat = 8'h00;
      fstat[3:0] = r_reg.count;
      fstat[`RSP_FST_HIGH] = (r_reg.count >= `RSP_FIFO_HIGH);
      fstat[`RSP_FST_LOW] = (r_reg.count < `RSP_FIFO_LOW);
      fstat[`RSP_FST_OVF] = r_reg.ovf;
      rd_val = 8'h00;
      if (r_reg.addr < 5'(`RSP_NUM_GEN)) begin
         rd_val = r_reg.gen[r_reg.addr[3:0]];
      end else begin
         unique case (r_reg.addr)
            `RSP_ADDR_IRQ: rd_val = r_reg.irq;
            `RSP_ADDR_MASK: rd_val = r_reg.mask;
            `RSP_ADDR_RSSI: rd_val = r_reg.rssi;
            `RSP_ADDR_FIFO_STAT: rd_val = fstat;
            `RSP_ADDR_FIFO: rd_val = fifo_rdata;
            default: rd_val = 8'h00;
         endcase
      end
      // Start and stop delimiters of the mode without select
      start_c = r_reg.mode_ok && !r_reg.ss_mode && mosi_rise && sclk_hi;
      stop_c = r_reg.mode_ok && !r_reg.ss_mode && mosi_fall && sclk_hi;
      word = {r_reg.rx_sr[6:0], r_reg.mosi_sync[1]};
      // Transfer engine
      if (!r_reg.mode_ok || (r_reg.ss_mode && ss_hi) || stop_c) begin
         r_next.state = RSP_IDLE;
         r_next.miso = 1'b0;
         r_next.need_load = 1'b0;
      end else if (start_c || (r_reg.ss_mode && r_reg.state == RSP_IDLE)) begin
         r_next.state = RSP_CMD;
         r_next.bitcnt = 3'h0;
         r_next.need_load = 1'b0;
      end else begin
         unique case (r_reg.state)
            RSP_IDLE: begin
               r_next.bitcnt = 3'h0;
            end
            RSP_CMD: begin
               if (sclk_rise) begin
                  r_next.rx_sr = word;
                  r_next.bitcnt = r_reg.bitcnt + 3'h1;
                  if (r_reg.bitcnt == 3'h7) begin
                     r_next.addr = word[4:0];
                     r_next.cont = word[`RSP_CW_CONT];
                     if (word[`RSP_CW_CMD]) begin
                        fifo_clr = (word[4:0] == `RSP_CMD_FIFO_RESET);
                     end else if (word[`RSP_CW_READ]) begin
                        r_next.state = RSP_RDATA;
                        r_next.need_load = 1'b1;
                     end else begin
                        r_next.state = RSP_WDATA;
                     end
                  end
               end
            end
            RSP_WDATA: begin
               if (sclk_rise) begin
                  r_next.rx_sr = word;
                  r_next.bitcnt = r_reg.bitcnt + 3'h1;
                  if (r_reg.bitcnt == 3'h7) begin
                     if (r_reg.addr < 5'(`RSP_NUM_GEN)) begin
                        r_next.gen[r_reg.addr[3:0]] = word;
                     end else if (r_reg.addr == `RSP_ADDR_MASK) begin
                        r_next.mask = word;
                     end
                     if (r_reg.cont) begin
                        r_next.addr = r_reg.addr + 5'h1;
                     end
                  end
               end
            end
            RSP_RDATA: begin
               if (r_reg.need_load) begin
                  // Byte loaded before its first falling edge
                  r_next.tx_sr = rd_val;
                  r_next.need_load = 1'b0;
                  r_next.bitcnt = 3'h0;
               end else if (sclk_fall) begin
                  r_next.miso = r_reg.tx_sr[7];
                  r_next.tx_sr = {r_reg.tx_sr[6:0], 1'b0};
                  r_next.bitcnt = r_reg.bitcnt + 3'h1;
                  if (r_reg.bitcnt == 3'h7) begin
                     r_next.irq_rd = (r_reg.addr == `RSP_ADDR_IRQ);
                     fifo_pop = (r_reg.addr == `RSP_ADDR_FIFO) && (r_reg.count != 4'h0);
                     if (r_reg.cont) begin
                        r_next.addr = r_reg.addr + 5'h1;
                     end
                  end
               end else if (sclk_rise && r_reg.bitcnt == 3'h0) begin
                  // Rising edge after a full byte fetches the next one
                  r_next.need_load = 1'b1;
               end
            end
            default: r_next.state = RSP_IDLE;
         endcase
      end
      // Air side events set status, masked events are not recorded
      // Push decided first, a byte arriving with the end counts as data
      fifo_push = i_rx_valid && (r_reg.count != 4'(`RSP_FIFO_DEPTH));
      irq_set[`RSP_IRQ_TX] = i_tx_done;
      irq_set[`RSP_IRQ_RX] = i_rx_end && !i_rx_error && (r_reg.count != 4'h0
         || fifo_push);
      irq_set[`RSP_IRQ_ERR] = i_rx_end && i_rx_error;
      irq_set[`RSP_IRQ_FIFO] = fifo_push && (r_reg.count == `RSP_FIFO_HIGH - 4'h1);
      irq_set = irq_set & ~r_reg.mask;
      // First clock of the byte after the status byte clears it, a new event wins.
      // The rising edge that samples the last status bit does not count, so a
      // frame without the dummy byte leaves the status set with select; without select the stop condition's clock rise clears it.
      if (r_reg.irq_rd && sclk_rise && r_reg.state == RSP_RDATA && r_reg.bitcnt == 3'h1) begin
         r_next.irq = irq_set;
         r_next.irq_rd = 1'b0;
      end else begin
         r_next.irq = r_reg.irq | irq_set;
      end
      if (r_next.state == RSP_IDLE) begin
         r_next.irq_rd = 1'b0;
      end
      if (i_rx_end) begin
         r_next.rssi = i_rssi;
      end
      // FIFO pointers and byte count
      if (i_rx_valid && !fifo_push) begin
         r_next.ovf = 1'b1;
      end
      cnt_next = r_reg.count;
      if (fifo_push) begin
         r_next.wr_ptr = ptr_inc(r_reg.wr_ptr);
         cnt_next = cnt_next + 4'h1;
      end
      if (fifo_pop) begin
         r_next.rd_ptr = ptr_inc(r_reg.rd_ptr);
         cnt_next = cnt_next - 4'h1;
      end
      r_next.count = cnt_next;
      if (fifo_clr) begin
         r_next.wr_ptr = 4'h0;
         r_next.rd_ptr = 4'h0;
         r_next.count = 4'h0;
         r_next.ovf = i_rx_valid && !fifo_push; // Overflow in the same cycle survives
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         r_reg <= '0;
         r_reg.irq <= `RSP_IRQ_RESET;
         r_reg.mask <= `RSP_MASK_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs
   assign o_miso = r_reg.miso;
   assign o_miso_oe_n = (r_reg.state != RSP_RDATA);
   assign o_irq = |r_reg.irq;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);

   logic ss_rise_h;
   logic sclk_rise_h;
   assign ss_rise_h = r_reg.ss_sync[1] & ~r_reg.ss_sync[2];
   assign sclk_rise_h = r_reg.sclk_sync[1] & ~r_reg.sclk_sync[2];

   // Strap decode, serial framing and status clear
   a_strap_equal: assert property ($rose(r_reg.strap_done) &&
      (r_reg.strap_s2 == 3'h0 || r_reg.strap_s2 == 3'h7) |-> !r_reg.mode_ok)
      else $error("equal straps enabled serial mode");
   a_irq_clear: assert property (r_reg.irq_rd && sclk_rise_h &&
      r_reg.state == RSP_RDATA && r_reg.bitcnt == 3'h1
      && !i_tx_done && !i_rx_end && !i_rx_valid |=> r_reg.irq == 8'h00)
      else $error("status not cleared after extra clock");
   a_ss_reset: assert property (r_reg.mode_ok && r_reg.ss_mode && ss_rise_h
      |=> r_reg.state == RSP_IDLE [*2])
      else $error("select high did not idle interface");
   a_stop_ends: assert property (r_reg.mode_ok && !r_reg.ss_mode && r_reg.sclk_sync[1]
      && $fell(r_reg.mosi_sync[1]) |=> r_reg.state == RSP_IDLE)
      else $error("stop condition ignored");
   a_start_arms: assert property (r_reg.mode_ok && !r_reg.ss_mode && r_reg.sclk_sync[1]
      && $rose(r_reg.mosi_sync[1]) |=> r_reg.state == RSP_CMD && r_reg.bitcnt == 3'h0)
      else $error("start condition ignored");
   a_no_drive_cmd: assert property (r_reg.state == RSP_CMD |-> o_miso_oe_n)
      else $error("output driven in command phase");
   // A read word has the command bit low and the read bit high
   a_read_entry: assert property (r_reg.state == RSP_CMD && sclk_rise_h &&
      r_reg.bitcnt == 3'h7 && !r_reg.rx_sr[6] && r_reg.rx_sr[5] && r_reg.mode_ok
      && $stable(r_reg.mosi_sync[1]) && !(r_reg.ss_mode && r_reg.ss_sync[1])
      |=> r_reg.state == RSP_RDATA ##1 !o_miso_oe_n)
      else $error("read phase not entered after command");
   // Status and FIFO
   a_irq_level: assert property ((r_reg.irq != 8'h00) == o_irq)
      else $error("interrupt out disagrees with status");
   a_tx_irq: assert property (i_tx_done && !r_reg.mask[`RSP_IRQ_TX]
      |=> r_reg.irq[`RSP_IRQ_TX] && o_irq)
      else $error("transmit done did not interrupt");
   a_fifo_ninth: assert property (i_rx_valid && r_reg.count == 4'h8 && !fifo_pop &&
      !fifo_clr && !r_reg.mask[`RSP_IRQ_FIFO]
      |=> r_reg.irq[`RSP_IRQ_FIFO] && r_reg.count == 4'h9)
      else $error("ninth byte did not raise FIFO flag");
   a_rssi_latch: assert property (i_rx_end |=> r_reg.rssi == $past(i_rssi))
      else $error("signal strength not captured");
   a_rx_irq: assert property (i_rx_end && !i_rx_error && r_reg.count != 4'h0 &&
      !r_reg.mask[`RSP_IRQ_RX] |=> r_reg.irq[`RSP_IRQ_RX])
      else $error("receive end did not set status");
   // Command word 0x8F: rx_sr holds its upper seven bits, data-in its last
   a_fifo_reset: assert property (r_reg.state == RSP_CMD && sclk_rise_h &&
      r_reg.bitcnt == 3'h7 && r_reg.rx_sr[6:0] == 7'h47 && r_reg.mosi_sync[1] &&
      !i_rx_valid && !(r_reg.ss_mode && r_reg.ss_sync[1]) && r_reg.mode_ok
      && !(!r_reg.ss_mode && r_reg.sclk_sync[1] && $changed(r_reg.mosi_sync[1]))
      |=> r_reg.count == 4'h0)
      else $error("FIFO reset command ignored");

   c_read: cover property (r_reg.state == RSP_RDATA ##1 r_reg.state == RSP_IDLE);
   c_irq_clear: cover property (o_irq ##1 !o_irq);
   c_fifo_high: cover property (r_reg.count == `RSP_FIFO_HIGH);
   c_no_select: cover property (!r_reg.ss_mode && r_reg.state == RSP_RDATA);
   c_fifo_clr: cover property (fifo_clr && r_reg.count != 4'h0);

endmodule

// ==== sim/rsp_host_model.sv ====
/*
 * Behavioural host that masters the serial port: start and stop in both
 * serial modes and one eight bit exchange at a time.
 * Assumes the bench calls its tasks a small delay after a rising i_clock.
 */
`timescale 1ns/1ns

module rsp_host_model
   import rsp_pkg::*;
(
   // Clock
   input wire logic i_clock,
   // Serial pins from the port
   input wire logic i_miso,
   input wire logic i_miso_oe_n,
   // Serial pins to the port
   output logic o_sclk,
   output logic o_mosi,
   output logic o_ss_n
);
   logic ss_mode;
   logic oe_seen;

   // Serial clock stands low outside frames
   initial begin
      o_sclk = 1'b0;
      o_mosi = 1'b0;
      o_ss_n = 1'b1;
      ss_mode = 1'b1;
      oe_seen = 1'b0;
   end

   // Quarter of a 400 ns serial clock period
   task automatic q();
      repeat (2) @(posedge i_clock);
      #2;
   endtask

   // Select low, or data-in rising while the clock is high
   task automatic start();
      if (ss_mode) begin
         o_ss_n = 1'b0;
         q();
      end else begin
         q();
         o_mosi = 1'b0;
         q();
         o_sclk = 1'b1;
         q();
         o_mosi = 1'b1;
         q();
         o_sclk = 1'b0;
      end
   endtask

   // Eight bits out MSB first, read data taken on the rising edge
   task automatic xfer(input logic [7:0] w, output logic [7:0] r);
      oe_seen = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         q();
         o_mosi = w[i];
         q();
         o_sclk = 1'b1;
         // A released data-out line reads as the inverse of what it last showed
         r[i] = i_miso_oe_n ? ~i_miso : i_miso;
         oe_seen = oe_seen | !i_miso_oe_n;
         q();
         q();
         o_sclk = 1'b0;
      end
   endtask

   // Select high with data-in flipped, or data-in falling while clock high
   task automatic stop();
      q();
      if (ss_mode) begin
         o_ss_n = 1'b1;
         o_mosi = ~o_mosi;
      end else begin
         o_mosi = 1'b1;
         q();
         o_sclk = 1'b1;
         q();
         o_mosi = 1'b0;
         q();
         o_sclk = 1'b0;
      end
      q();
      q();
   endtask
endmodule

// ==== sim/rsp_serial_port_bench.sv ====
/*
 * Self-checking bench of the serial port: registers, status clear by
 * dummy read, receive FIFO, both serial modes and the disabled straps.
 * Assumes rsp_host_model plays the host on the serial pins.
 */
`timescale 1ns/1ns
`include "rsp_cfg.svh"

`define RSP_CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module rsp_serial_port_bench
   import rsp_pkg::*;
;
   logic i_clock, i_reset_n, i_sclk, i_mosi, i_ss_n, o_miso, o_miso_oe_n;
   logic i_tx_done, i_rx_valid, i_rx_end, i_rx_error, o_irq;
   logic [2:0] i_strap;
   logic [7:0] i_rx_data, i_rssi, b;
   logic [7:0] txq[$], rxq[$], exp_q[$];
   logic oeq[$];
   int n_mismatch, n_tests;

   // ****************************************************************
   // Clock, design and host
   // ****************************************************************
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   rsp_serial_port dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_strap(i_strap),
      .i_sclk(i_sclk), .i_mosi(i_mosi), .i_ss_n(i_ss_n), .o_miso(o_miso),
      .o_miso_oe_n(o_miso_oe_n), .i_tx_done(i_tx_done), .i_rx_valid(i_rx_valid),
      .i_rx_data(i_rx_data), .i_rx_end(i_rx_end), .i_rx_error(i_rx_error),
      .i_rssi(i_rssi), .o_irq(o_irq));

   rsp_host_model host (.i_clock(i_clock), .i_miso(o_miso), .i_miso_oe_n(o_miso_oe_n),
      .o_sclk(i_sclk), .o_mosi(i_mosi), .o_ss_n(i_ss_n));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Expected FIFO status for a byte count with no overflow
   function automatic logic [7:0] fstat(input int c);
      return {1'b0, c >= 9, c < 3, 1'b0, 4'(c)};
   endfunction

   // Reset with the given straps, then let the strap capture settle
   task automatic rst(input logic [2:0] s);
      i_strap = s;
      i_reset_n = 1'b0;
      repeat (8) @(posedge i_clock);
      #2;
      i_reset_n = 1'b1;
      repeat (10) @(posedge i_clock);
      #2;
   endtask

   // One cycle air event pulse
   task automatic air(input logic tx, input logic rv, input logic re);
      i_tx_done = tx;
      i_rx_valid = rv;
      i_rx_end = re;
      @(posedge i_clock);
      #2;
      {i_tx_done, i_rx_valid, i_rx_end} = 3'h0;
      repeat (3) @(posedge i_clock);
      #2;
   endtask

   // One frame of the words in txq, answers into rxq and oeq
   task automatic frame();
      rxq.delete();
      oeq.delete();
      host.start();
      foreach (txq[i]) begin
         host.xfer(txq[i], b);
         rxq.push_back(b);
         oeq.push_back(host.oe_seen);
      end
      host.stop();
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      n_mismatch = 0;
      n_tests = 0;
      {i_tx_done, i_rx_valid, i_rx_end, i_rx_error} = 4'h0;
      i_rx_data = 8'h00;
      i_rssi = 8'h00;
      void'($urandom(32'h33CA));
      rst(3'h1);
      `RSP_CHK(o_irq, 1'b0)
      `RSP_CHK(o_miso_oe_n, 1'b1)
      // General registers written and read back in one burst each
      txq = {8'h20};
      exp_q.delete();
      for (int i = 0; i < `RSP_NUM_GEN; i++) begin
         exp_q.push_back(8'($urandom));
         txq.push_back(exp_q[i]);
      end
      frame();
      txq = {8'h60};
      for (int i = 0; i < `RSP_NUM_GEN; i++) txq.push_back(8'h00);
      frame();
      `RSP_CHK(oeq[0], 1'b0)
      `RSP_CHK(oeq[1], 1'b1)
      for (int i = 0; i < `RSP_NUM_GEN; i++) `RSP_CHK(rxq[i + 1], exp_q[i])
      txq = {8'h4E, 8'h00};
      frame();
      `RSP_CHK(rxq[1], 8'h00)
      done("registers");
      // Transmit done, status read without and with the dummy byte
      air(1'b1, 1'b0, 1'b0);
      `RSP_CHK(o_irq, 1'b1)
      txq = {`RSP_READ_IRQ_CONT, 8'h00};
      frame();
      `RSP_CHK(rxq[1], `RSP_STAT_TX_DONE)
      `RSP_CHK(o_irq, 1'b1)
      txq = {`RSP_READ_IRQ_CONT, 8'h00, 8'h00};
      frame();
      `RSP_CHK(rxq[1], `RSP_STAT_TX_DONE)
      `RSP_CHK(rxq[2], `RSP_MASK_RESET)
      `RSP_CHK(o_irq, 1'b0)
      done("status clear");
      // Nine received bytes, end of reception, FIFO drain and reset
      exp_q.delete();
      for (int i = 0; i < 9; i++) begin
         `RSP_CHK(o_irq, 1'b0)
         i_rx_data = 8'($urandom);
         exp_q.push_back(i_rx_data);
         air(1'b0, 1'b1, 1'b0);
      end
      `RSP_CHK(o_irq, 1'b1)
      i_rssi = 8'($urandom);
      air(1'b0, 1'b0, 1'b1);
      txq = {`RSP_READ_IRQ_CONT, 8'h00, 8'h00};
      frame();
      `RSP_CHK(rxq[1], 8'h60)
      txq = {8'h5C, 8'h00, 8'h00};
      frame();
      `RSP_CHK(rxq[1], fstat(9))
      txq = {8'h5F};
      for (int i = 0; i < 9; i++) txq.push_back(8'h00);
      frame();
      for (int i = 0; i < 9; i++) `RSP_CHK(rxq[i + 1], exp_q[i])
      txq = {8'h4F, 8'h00};
      frame();
      `RSP_CHK(rxq[1], i_rssi)
      i_rx_data = 8'($urandom);
      air(1'b0, 1'b1, 1'b0);
      txq = {8'h8F, 8'h5C, 8'h00};
      frame();
      `RSP_CHK(rxq[2], fstat(0))
      i_rx_error = 1'b1;
      air(1'b0, 1'b0, 1'b1);
      i_rx_error = 1'b0;
      txq = {`RSP_READ_IRQ_CONT, 8'h00, 8'h00};
      frame();
      `RSP_CHK(rxq[1], 8'h10)
      `RSP_CHK(o_irq, 1'b0)
      done("receive");
      // Serial mode without select: start and stop by data-in edges
      rst(3'h6);
      host.ss_mode = 1'b0;
      b = 8'($urandom);
      txq = {8'h03, b};
      frame();
      txq = {8'h43, 8'h00};
      frame();
      `RSP_CHK(rxq[1], b)
      `RSP_CHK(o_miso_oe_n, 1'b1)
      done("no select");
      // Straps all equal leave the port silent
      rst(3'h0);
      host.ss_mode = 1'b1;
      txq = {8'h43, 8'h00};
      frame();
      `RSP_CHK(oeq[1], 1'b0)
      done("straps");
      final_report();
   end

   // Cut a hang short
   initial begin
      repeat (40000) @(posedge i_clock);
      n_mismatch++;
      $display("unexpected at %0t: watchdog expired", $time);
      final_report();
   end
endmodule
